// ### msd_consts.vh
// Constants for the multi-stream transfer engine
`ifndef MSD_CONSTS_VH
`define MSD_CONSTS_VH
`define MSD_NSTR 8
`define MSD_SW 3
`define MSD_FDEPTH 8
`define MSD_FAW 3
`define MSD_BURST 3'h4
// Register offsets, one per controller block; stream registers at base + 0x20 * stream
`define MSD_CTRL_OFF 8'h00
`define MSD_CFG_OFF 8'h00
`define MSD_SRC_OFF 8'h04
`define MSD_DST_OFF 8'h08
`define MSD_CNT_OFF 8'h0c
`define MSD_DST2_OFF 8'h10
`define MSD_STAT_OFF 12'h100
`define MSD_MASK_OFF 12'h104
`define MSD_SWTRIG_OFF 12'h108
`define MSD_CTL1_SEL 12'h200
// Config fields
`define MSD_CFG_EN 0
`define MSD_CFG_DIR_LO 1
`define MSD_CFG_CIRC 3
`define MSD_CFG_DBUF 4
`define MSD_CFG_SSZ_LO 5
`define MSD_CFG_DSZ_LO 7
`define MSD_CFG_CUR 9
`define MSD_DIR_M2M 2'h2
`define MSD_DIR_P2M 2'h0
`define MSD_DIR_M2P 2'h1
`endif

// ### msd_arbiter.v
// Fixed-priority arbiter: lowest stream index wins
`timescale 1ns/1ps
module msd_arbiter (
  // Requests
  input wire [7:0] req,
  // Grant
  output reg [2:0] gnt_idx,
  output wire gnt_any
);
  integer i;
  assign gnt_any = |req;
  always @* begin
    gnt_idx = 3'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (req[i]) begin
        gnt_idx = i[2:0];
      end
    end
  end
endmodule

// ### msd_fifo.v
// Shared staging FIFO holding bytes between read and write sides
`timescale 1ns/1ps
`include "msd_consts.vh"
module msd_fifo (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire flush,
  // Push up to four bytes
  input wire push,
  input wire [2:0] push_n,
  input wire [31:0] push_data,
  // Pop up to four bytes
  input wire pop,
  input wire [2:0] pop_n,
  output wire [31:0] pop_data,
  output reg [3:0] level_q
);
  reg [7:0] mem [0:`MSD_FDEPTH-1];
  reg [2:0] wp_q;
  reg [2:0] rp_q;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rd
      localparam [2:0] OFS = g;
      assign pop_data[8*g+7:8*g] = mem[rp_q + OFS];
    end
  endgenerate
  integer k;
  always @(posedge pclk) begin
    if (push) begin
      for (k = 0; k < 4; k = k + 1) begin
        if (k < push_n) begin
          mem[wp_q + k[2:0]] <= push_data[8*k +: 8];
        end
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      level_q <= 4'h0;
    end else if (flush) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      level_q <= 4'h0;
    end else begin
      if (push) begin
        wp_q <= wp_q + push_n;
      end
      if (pop) begin
        rp_q <= rp_q + pop_n;
      end
      level_q <= level_q + (push ? {1'b0, push_n} : 4'h0) - (pop ? {1'b0, pop_n} : 4'h0);
    end
  end
endmodule

// ### msd_top.v
// Two-controller, sixteen-stream (eight per controller) transfer engine with APB registers and AHB master ports
`timescale 1ns/1ps
`include "msd_consts.vh"
module msd_ctl (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Register access from the APB slave
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  // Synchronised stream requests
  input wire [7:0] dreq,
  // AHB master
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [2:0] hburst,
  output reg [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hready,
  input wire hresp,
  // Interrupt
  output wire irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RD = 2'h1;
  localparam ST_WR = 2'h2;
  localparam ST_DONE = 2'h3;
  // Bus phases of one beat: issue address, address phase, data phase
  localparam PH_ADDR = 2'h0;
  localparam PH_AP = 2'h1;
  localparam PH_DP = 2'h2;
  reg [9:0] cfg_q [0:7];
  reg [31:0] src_q [0:7];
  reg [31:0] dst_q [0:7];
  reg [31:0] dst2_q [0:7];
  reg [15:0] cnt_q [0:7];
  reg [31:0] src_cur_q [0:7];
  reg [31:0] dst_cur_q [0:7];
  reg [15:0] left_q [0:7];
  reg [7:0] stat_q;
  reg [7:0] mask_q;
  reg [7:0] swtrig_q;
  reg [1:0] state_q;
  reg [2:0] act_q;
  reg [2:0] beat_q;
  reg [1:0] ph_q;
  wire [7:0] want;
  wire [2:0] gidx;
  wire gany;
  wire [3:0] level;
  wire [31:0] fdata;
  wire [2:0] sidx = reg_addr[7:5];
  wire [7:0] sreg = {3'h0, reg_addr[4:0]};
  wire [9:0] acfg = cfg_q[act_q];
  wire [1:0] ssz = acfg[`MSD_CFG_SSZ_LO +: 2];
  wire [1:0] dsz = acfg[`MSD_CFG_DSZ_LO +: 2];
  wire [2:0] sbytes = 3'h1 << ssz;
  wire [2:0] dbytes = 3'h1 << dsz;
  wire [1:0] dir = acfg[`MSD_CFG_DIR_LO +: 2];
  wire last_beat = (left_q[act_q] == 16'h1);
  wire fin = (state_q == ST_WR) && (ph_q == PH_DP) && hready && last_beat &&
    acfg[`MSD_CFG_EN];
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_want
      assign want[g] = cfg_q[g][`MSD_CFG_EN] && (left_q[g] != 16'h0) &&
        (dreq[g] || swtrig_q[g] || (cfg_q[g][`MSD_CFG_DIR_LO +: 2] == `MSD_DIR_M2M));
    end
  endgenerate
  msd_arbiter u_arb (
    .req(want),
    .gnt_idx(gidx),
    .gnt_any(gany)
  );
  msd_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(state_q == ST_IDLE),
    .push((state_q == ST_RD) && (ph_q == PH_DP) && hready),
    .push_n(sbytes),
    // Narrow reads arrive on the byte lanes of their address
    .push_data(hrdata >> {haddr[1:0], 3'h0}),
    .pop((state_q == ST_WR) && (ph_q == PH_ADDR)),
    .pop_n(dbytes),
    .pop_data(fdata),
    .level_q(level)
  );
  assign irq = |(stat_q & mask_q);
  always @* begin
    reg_rdata = 32'h0;
    if (reg_addr == `MSD_STAT_OFF) begin
      reg_rdata = {24'h0, stat_q};
    end else if (reg_addr == `MSD_MASK_OFF) begin
      reg_rdata = {24'h0, mask_q};
    end else if (reg_addr == `MSD_SWTRIG_OFF) begin
      reg_rdata = {24'h0, swtrig_q};
    end else if (reg_addr[11:8] == 4'h0) begin
      if (sreg == `MSD_CFG_OFF) begin
        reg_rdata = {22'h0, cfg_q[sidx]};
      end else if (sreg == `MSD_SRC_OFF) begin
        reg_rdata = src_q[sidx];
      end else if (sreg == `MSD_DST_OFF) begin
        reg_rdata = dst_q[sidx];
      end else if (sreg == `MSD_CNT_OFF) begin
        reg_rdata = {left_q[sidx], cnt_q[sidx]};
      end else if (sreg == `MSD_DST2_OFF) begin
        reg_rdata = dst2_q[sidx];
      end
    end
  end
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        cfg_q[i] <= 10'h0;
        src_q[i] <= 32'h0;
        dst_q[i] <= 32'h0;
        dst2_q[i] <= 32'h0;
        cnt_q[i] <= 16'h0;
        src_cur_q[i] <= 32'h0;
        dst_cur_q[i] <= 32'h0;
        left_q[i] <= 16'h0;
      end
      stat_q <= 8'h0;
      mask_q <= 8'h0;
      swtrig_q <= 8'h0;
      state_q <= ST_IDLE;
      act_q <= 3'h0;
      beat_q <= 3'h0;
      ph_q <= PH_ADDR;
      haddr <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= 3'h0;
      hburst <= 3'h0;
      hwdata <= 32'h0;
    end else begin
      // Read clears status; a completion in the same cycle wins
      if (reg_rd && reg_addr == `MSD_STAT_OFF) begin
        stat_q <= 8'h0;
      end
      if (reg_wr) begin
        if (reg_addr == `MSD_MASK_OFF) begin
          mask_q <= reg_wdata[7:0];
        end else if (reg_addr == `MSD_SWTRIG_OFF) begin
          swtrig_q <= swtrig_q | reg_wdata[7:0];
        end else if (reg_addr[11:8] == 4'h0) begin
          if (sreg == `MSD_CFG_OFF) begin
            cfg_q[sidx] <= reg_wdata[9:0];
            // Enabling loads working copies
            if (reg_wdata[`MSD_CFG_EN]) begin
              src_cur_q[sidx] <= src_q[sidx];
              dst_cur_q[sidx] <= dst_q[sidx];
              left_q[sidx] <= cnt_q[sidx];
            end else begin
              left_q[sidx] <= 16'h0;
            end
          end else if (sreg == `MSD_SRC_OFF) begin
            src_q[sidx] <= reg_wdata;
          end else if (sreg == `MSD_DST_OFF) begin
            dst_q[sidx] <= reg_wdata;
          end else if (sreg == `MSD_CNT_OFF) begin
            cnt_q[sidx] <= reg_wdata[15:0];
          end else if (sreg == `MSD_DST2_OFF) begin
            dst2_q[sidx] <= reg_wdata;
          end
        end
      end
      case (state_q)
        ST_IDLE: begin
          htrans <= 2'h0;
          if (gany) begin
            act_q <= gidx;
            swtrig_q[gidx] <= 1'b0;
            state_q <= ST_RD;
            beat_q <= 3'h0;
            ph_q <= PH_ADDR;
          end
        end
        ST_RD: begin
          // one read beat of source width
          if (ph_q == PH_ADDR) begin
            haddr <= src_cur_q[act_q];
            htrans <= 2'h2;
            hwrite <= 1'b0;
            hsize <= {1'b0, ssz};
            hburst <= 3'h1;
            ph_q <= PH_AP;
          end else if (hready && ph_q == PH_AP) begin
            // Address accepted; read data comes in the next phase
            htrans <= 2'h0;
            ph_q <= PH_DP;
          end else if (hready) begin
            ph_q <= PH_ADDR;
            if (dir != `MSD_DIR_P2M) begin
              src_cur_q[act_q] <= src_cur_q[act_q] + {29'h0, sbytes};
            end
            if (!acfg[`MSD_CFG_EN]) begin
              state_q <= ST_IDLE;
            end else if ({1'b0, level} + {2'h0, sbytes} >= {2'h0, dbytes}) begin
              state_q <= ST_WR;
            end
          end
        end
        ST_WR: begin
          if (ph_q == PH_ADDR) begin
            haddr <= dst_cur_q[act_q];
            // Single beats: a read may sit between two writes, so no SEQ
            htrans <= 2'h2;
            hwrite <= 1'b1;
            hsize <= {1'b0, dsz};
            hburst <= 3'h1;
            hwdata <= fdata << {dst_cur_q[act_q][1:0], 3'h0};
            ph_q <= PH_AP;
          end else if (hready && ph_q == PH_AP) begin
            htrans <= 2'h0;
            ph_q <= PH_DP;
          end else if (hready) begin
            ph_q <= PH_ADDR;
            left_q[act_q] <= left_q[act_q] - 16'h1;
            if (dir != `MSD_DIR_M2P) begin
              dst_cur_q[act_q] <= dst_cur_q[act_q] + {29'h0, dbytes};
            end
            beat_q <= beat_q + 3'h1;
            // A stream disabled mid-transfer is dropped after this beat
            if (!acfg[`MSD_CFG_EN]) begin
              state_q <= ST_IDLE;
            end else if (last_beat) begin
              state_q <= ST_DONE;
            // keep the bus for a burst of beats
            end else if (beat_q + 3'h1 == `MSD_BURST) begin
              state_q <= ST_IDLE;
            end else if (level >= {1'b0, dbytes}) begin
              state_q <= ST_WR;
            end else begin
              state_q <= ST_RD;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
          if (acfg[`MSD_CFG_DBUF]) begin
            cfg_q[act_q][`MSD_CFG_CUR] <= ~acfg[`MSD_CFG_CUR];
            dst_cur_q[act_q] <= acfg[`MSD_CFG_CUR] ? dst_q[act_q] : dst2_q[act_q];
            src_cur_q[act_q] <= src_q[act_q];
            left_q[act_q] <= cnt_q[act_q];
          end else if (acfg[`MSD_CFG_CIRC]) begin
            src_cur_q[act_q] <= src_q[act_q];
            dst_cur_q[act_q] <= dst_q[act_q];
            left_q[act_q] <= cnt_q[act_q];
          end else begin
            cfg_q[act_q][`MSD_CFG_EN] <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (fin) begin
        stat_q[act_q] <= 1'b1;
      end
    end
  end
endmodule

module msd_top (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Stream request lines from peripherals, controller 0 then 1
  input wire [15:0] dreq,
  // AHB master of controller 0
  output wire [31:0] haddr0,
  output wire [1:0] htrans0,
  output wire hwrite0,
  output wire [2:0] hsize0,
  output wire [2:0] hburst0,
  output wire [31:0] hwdata0,
  input wire [31:0] hrdata0,
  input wire hready0,
  input wire hresp0,
  // AHB master of controller 1
  output wire [31:0] haddr1,
  output wire [1:0] htrans1,
  output wire hwrite1,
  output wire [2:0] hsize1,
  output wire [2:0] hburst1,
  output wire [31:0] hwdata1,
  input wire [31:0] hrdata1,
  input wire hready1,
  input wire hresp1,
  // Interrupts
  output wire irq0,
  output wire irq1
);
  reg [15:0] dreq_s1_q;
  reg [15:0] dreq_s2_q;
  wire acc = psel && penable;
  wire sel1 = paddr[9];
  wire [11:0] laddr = {3'h0, paddr[8:0]};
  wire [31:0] rd0;
  wire [31:0] rd1;
  wire hit_stat = (laddr == `MSD_STAT_OFF) || (laddr == `MSD_MASK_OFF) ||
    (laddr == `MSD_SWTRIG_OFF);
  wire mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
    (hit_stat || (laddr[8] == 1'b0 && laddr[4:0] <= 5'h10));
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = mapped ? (sel1 ? rd1 : rd0) : 32'h0;
  // Requests are asynchronous to pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreq_s1_q <= 16'h0;
      dreq_s2_q <= 16'h0;
    end else begin
      dreq_s1_q <= dreq;
      dreq_s2_q <= dreq_s1_q;
    end
  end
  msd_ctl u_c0 (
    .pclk(pclk), .presetn(presetn),
    .reg_wr(acc && pwrite && mapped && !sel1), .reg_rd(acc && !pwrite && mapped && !sel1),
    .reg_addr(laddr), .reg_wdata(pwdata), .reg_rdata(rd0), .dreq(dreq_s2_q[7:0]),
    .haddr(haddr0), .htrans(htrans0), .hwrite(hwrite0), .hsize(hsize0), .hburst(hburst0),
    .hwdata(hwdata0), .hrdata(hrdata0), .hready(hready0), .hresp(hresp0), .irq(irq0)
  );
  msd_ctl u_c1 (
    .pclk(pclk), .presetn(presetn),
    .reg_wr(acc && pwrite && mapped && sel1), .reg_rd(acc && !pwrite && mapped && sel1),
    .reg_addr(laddr), .reg_wdata(pwdata), .reg_rdata(rd1), .dreq(dreq_s2_q[15:8]),
    .haddr(haddr1), .htrans(htrans1), .hwrite(hwrite1), .hsize(hsize1), .hburst(hburst1),
    .hwdata(hwdata1), .hrdata(hrdata1), .hready(hready1), .hresp(hresp1), .irq(irq1)
  );
endmodule

// ### msd_monitor.sv
// Assertion checker bound to the transfer engine top
`timescale 1ns/1ps
module msd_monitor (
  // Clock, reset and APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // AHB master of controller 0
  input wire [31:0] haddr0,
  input wire [1:0] htrans0,
  input wire [2:0] hsize0,
  input wire [2:0] hburst0,
  input wire hready0,
  // Interrupts
  input wire irq0,
  input wire irq1
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err_ph; pslverr |-> acc; endproperty
  a_err_ph: assert property (p_err_ph) else $error("pslverr outside access");
  property p_err_ua; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_err_ua: assert property (p_err_ua) else $error("unaligned not refused");
  property p_ok; acc && paddr == 12'h104 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mask access refused");
  property p_irq0; $fell(irq0) |-> $past(acc && paddr[11:3] == 9'h20); endproperty
  a_irq0: assert property (p_irq0) else $error("irq0 fell without status or mask access");
  property p_irq1; $fell(irq1) |-> $past(acc && paddr[11:3] == 9'h60); endproperty
  a_irq1: assert property (p_irq1) else $error("irq1 fell without status or mask access");
  property p_hold; htrans0[1] && !hready0 |=> $stable(haddr0) && $stable(htrans0); endproperty
  a_hold: assert property (p_hold) else $error("address phase changed in wait");
  property p_burst; htrans0[1] |-> hburst0 == 3'h1 && hsize0 <= 3'h2; endproperty
  a_burst: assert property (p_burst) else $error("bad burst or size");
  property p_seq; htrans0 == 2'h3 |-> $past(htrans0[1]); endproperty
  a_seq: assert property (p_seq) else $error("sequential beat without start");
endmodule
bind msd_top msd_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .haddr0(haddr0), .htrans0(htrans0),
  .hsize0(hsize0), .hburst0(hburst0), .hready0(hready0), .irq0(irq0), .irq1(irq1));

// ### msd_mem.sv
// Word memory behind one AHB master port, optionally with wait states
`timescale 1ns/1ps
module msd_mem #(parameter SLOW = 0) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // AHB slave side
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hready,
  output wire hresp
);
  reg [31:0] mem [0:63];
  reg [5:0] idx_q;
  reg wr_q;
  reg rd_q;
  reg tog_q;
  integer i;
  initial for (i = 0; i < 64; i = i + 1) mem[i] = 32'h1000 + i;
  // slow variant stalls every other cycle
  assign hready = !(SLOW && tog_q);
  assign hresp = 1'b0;
  // Outside a read data phase the bus carries junk that changes each cycle
  assign hrdata = rd_q ? mem[idx_q] : ({32{tog_q}} ^ 32'h5a5a5a5a);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= !tog_q;
      if (hready) begin
        if (wr_q)
          mem[idx_q] <= hwdata;
        wr_q <= htrans[1] && hwrite;
        rd_q <= htrans[1] && !hwrite;
        idx_q <= haddr[7:2];
      end
    end
  end
endmodule

// ### tb.sv
// Self-checking bench for the two-controller transfer engine
`timescale 1ns/1ps
module tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0;
  reg [15:0] dreq = 16'h0;
  wire [31:0] prdata, haddr0, hwdata0, hrdata0, haddr1, hwdata1, hrdata1;
  wire pready, pslverr, irq0, irq1, hwrite0, hready0, hresp0, hwrite1, hready1, hresp1;
  wire [1:0] htrans0, htrans1;
  wire [2:0] hsize0, hburst0, hsize1, hburst1;
  integer num_errors = 0;
  integer compares = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] rd;
  reg err;
  initial forever #2.5 pclk = ~pclk;
  msd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dreq(dreq), .haddr0(haddr0), .htrans0(htrans0), .hwrite0(hwrite0),
    .hsize0(hsize0), .hburst0(hburst0), .hwdata0(hwdata0), .hrdata0(hrdata0),
    .hready0(hready0), .hresp0(hresp0), .haddr1(haddr1), .htrans1(htrans1),
    .hwrite1(hwrite1), .hsize1(hsize1), .hburst1(hburst1), .hwdata1(hwdata1),
    .hrdata1(hrdata1), .hready1(hready1), .hresp1(hresp1), .irq0(irq0), .irq1(irq1));
  msd_mem #(.SLOW(1)) mem0_u (.pclk(pclk), .presetn(presetn), .haddr(haddr0),
    .htrans(htrans0), .hwrite(hwrite0), .hwdata(hwdata0), .hrdata(hrdata0),
    .hready(hready0), .hresp(hresp0));
  msd_mem #(.SLOW(0)) mem1_u (.pclk(pclk), .presetn(presetn), .haddr(haddr1),
    .htrans(htrans1), .hwrite(hwrite1), .hwdata(hwdata1), .hrdata(hrdata1),
    .hready(hready1), .hresp(hresp1));
  task finish_test;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; an idle cycle follows so the next setup is a fresh edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  task run(input [11:0] b, input [31:0] s, input [31:0] d, input [15:0] n, input [31:0] cfg);
    begin
      wr(b + 12'h4, s);
      wr(b + 12'h8, d);
      wr(b + 12'hc, {16'h0, n});
      wr(b, cfg);
    end
  endtask
  task wait_irq(input c);
    integer n;
    begin
      n = 0;
      while ((c ? irq1 : irq0) !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n = n + 1;
      end
      chk(c ? irq1 : irq0, 1'b1);
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(12'h000, 32'h0);
    rdc(12'h100, 32'h0);
    rdc(12'h104, 32'h0);
    apb(1'b0, 12'h3fc, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'h105, 32'hff);
    chk(err, 1'b1);
    rdc(12'h104, 32'h0);
    wr(12'h264, 32'h12345678);
    rdc(12'h264, 32'h12345678);
    rdc(12'h064, 32'h0);
    wr(12'h104, 32'hff);
    wr(12'h304, 32'hff);
    run(12'h000, 32'h0, 32'h40, 16'h4, 32'h145);
    wait_irq(1'b0);
    for (i = 0; i < 4; i = i + 1) chk(mem0_u.mem[16 + i], 32'h1000 + i);
    wr(12'h104, 32'h0);
    chk(irq0, 1'b0);
    wr(12'h104, 32'hff);
    chk(irq0, 1'b1);
    rdc(12'h100, 32'h1);
    chk(irq0, 1'b0);
    rdc(12'h100, 32'h0);
    run(12'h240, 32'h80, 32'h40, 16'h2, 32'h141);
    rdc(12'h300, 32'h0);
    dreq[10] <= 1'b1;
    wait_irq(1'b1);
    dreq[10] <= 1'b0;
    chk(mem1_u.mem[16], 32'h1020);
    chk(mem1_u.mem[17], 32'h1020);
    rdc(12'h300, 32'h4);
    run(12'h020, 32'h10, 32'h90, 16'h1, 32'h143);
    rdc(12'h100, 32'h0);
    wr(12'h108, 32'h2);
    wait_irq(1'b0);
    chk(mem0_u.mem[36], 32'h1004);
    rdc(12'h100, 32'h2);
    run(12'h0c0, 32'h30, 32'hd0, 16'h1, 32'h105);
    wait_irq(1'b0);
    chk(mem0_u.mem[52], 32'h100c);
    rdc(12'h100, 32'h40);
    run(12'h080, 32'h20, 32'ha0, 16'h1, 32'h14d);
    wait_irq(1'b0);
    apb(1'b0, 12'h100, 32'h0);
    wait_irq(1'b0);
    apb(1'b0, 12'h080, 32'h0);
    chk(rd[0], 1'b1);
    wr(12'h080, 32'h0);
    chk(mem0_u.mem[40], 32'h1008);
    apb(1'b0, 12'h100, 32'h0);
    wr(12'h0b0, 32'hc0);
    run(12'h0a0, 32'h24, 32'hb0, 16'h1, 32'h155);
    wait_irq(1'b0);
    apb(1'b0, 12'h100, 32'h0);
    wait_irq(1'b0);
    wr(12'h0a0, 32'h0);
    chk(mem0_u.mem[44], 32'h1009);
    chk(mem0_u.mem[48], 32'h1009);
    finish_test;
  end
endmodule
